// file: core/erd_regs.sv
`timescale 1ns/1ps
module erd_regs #(
	parameter int NUM_INTR = erd_pkg::NUM_INTR,
	parameter int NUM_DOORBELL = erd_pkg::NUM_DOORBELL
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Memory access behind the first base address register
	input wire logic [31:0] bar0_base,
	input wire logic [31:0] runtime_offset,
	input wire logic [31:0] doorbell_offset,
	input wire logic [31:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_rvalid,
	// Device events
	input wire logic [NUM_INTR-1:0] handler_busy_set,
	// Values to the ring engines
	output logic [NUM_INTR*16-1:0] ring_table_entry_count,
	output logic [NUM_INTR*64-1:0] ring_table_base_field,
	output logic [NUM_INTR*64-1:0] ring_read_pointer_field,
	output logic db_ring_ff,
	output logic [6:0] db_index_ff,
	output logic [7:0] ring_target_code,
	output logic [15:0] ring_stream_id
);
	// ************
	// Decode
	// ************
	logic [31:0] rt_rel;
	logic [31:0] db_rel;
	logic in_rt;
	logic in_db;
	logic [2:0] intr_sel;
	logic [3:0] word_sel;
	logic [31:0] set_rdata [NUM_INTR];

	assign rt_rel = mem_addr - (bar0_base + runtime_offset);
	assign db_rel = mem_addr - (bar0_base + doorbell_offset);
	// Sets 0..7 span 20h..11Fh
	assign in_rt = rt_rel >= 32'h0000_0020 && rt_rel < 32'h0000_0120 && rt_rel[1:0] == 2'b00;
	assign in_db = db_rel < 32'(NUM_DOORBELL) * 32'h0000_0004 && db_rel[1:0] == 2'b00;
	assign intr_sel = 3'(((rt_rel - 32'h0000_0020) >> 5));
	assign word_sel = {1'b0, rt_rel[4:2]};

	// ************
	// Interrupter sets
	// ************
	for (genvar i = 0; i < NUM_INTR; i++) begin : g_set
		erd_intr_set u_set (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.wr_en(mem_wr && in_rt && intr_sel == 3'(i)),
			.rd_en(mem_rd && in_rt && intr_sel == 3'(i)),
			.sel(word_sel),
			.wdata(mem_wdata),
			.busy_set(handler_busy_set[i]),
			.rdata(set_rdata[i]),
			.ring_table_entry_count(ring_table_entry_count[i*16 +: 16]),
			.ring_table_base_field(ring_table_base_field[i*64 +: 64]),
			.ring_read_pointer_field(ring_read_pointer_field[i*64 +: 64])
		);
	end

	// ************
	// Read path
	// ************
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_rdata <= erd_pkg::REG_RESET;
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= mem_rd;
			// Doorbells always read zero
			if (mem_rd && in_rt) begin
				mem_rdata <= set_rdata[intr_sel];
			end else begin
				mem_rdata <= 32'h0000_0000;
			end
		end
	end

	// ************
	// Doorbell strobe
	// ************
	// Write-only: a write gives a one-cycle ring pulse; index, target code and stream id hold until the next doorbell write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			db_ring_ff <= 1'b0;
			db_index_ff <= 7'h00;
			ring_target_code <= 8'h00;
			ring_stream_id <= 16'h0000;
		end else begin
			db_ring_ff <= mem_wr && in_db && !in_rt;
			if (mem_wr && in_db && !in_rt) begin
				db_index_ff <= 7'(db_rel >> 2);
				ring_target_code <= mem_wdata[7:0];
				ring_stream_id <= mem_wdata[31:16];
			end
		end
	end

	// ************
	// Checks
	// ************
	a_rvalid_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd |=> mem_rvalid) else $error("read not answered");
	a_db_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd && in_db && !in_rt |=> mem_rdata == 32'h0000_0000) else $error("doorbell read");
	a_db_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_db && !in_rt |=> db_ring_ff && ring_target_code == $past(mem_wdata[7:0]))
		else $error("doorbell lost");
	a_base_align: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ring_table_base_field[3:0] == 4'h0) else $error("base unaligned");
	a_size_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_rt && rt_rel == 32'h0000_0028 |=>
		ring_table_entry_count[15:0] == $past(mem_wdata[15:0])) else $error("size lost");
	a_busy_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
		handler_busy_set[0] |=> ring_read_pointer_field[3]) else $error("busy not set");
	a_busy_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd && in_rt && rt_rel == 32'h0000_0038 && !handler_busy_set[0] |=>
		!ring_read_pointer_field[3]) else $error("busy not cleared");
	a_index_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_rt && rt_rel == 32'h0000_0038 |=>
		ring_read_pointer_field[2:0] == $past(mem_wdata[2:0])) else $error("index lost");
	c_db_ring: cover property (@(posedge ref_clk) db_ring_ff);
	c_busy_read: cover property (@(posedge ref_clk) ring_read_pointer_field[3] ##1 mem_rd);
	c_rt_read: cover property (@(posedge ref_clk) mem_rd && in_rt);

	// ************
	// Further checks
	// ************
	// Interrupter 0 stands in for all sets; the sets share one module
	a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!mem_rd |=> !mem_rvalid) else $error("stray read valid");
	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!mem_rd |=> mem_rdata == 32'h0000_0000) else $error("read data not idle");
	a_size_reserved: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd && in_rt && word_sel == 4'h2 |=> mem_rdata[31:16] == 16'h0000)
		else $error("size upper bits set");
	a_size_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd && in_rt && rt_rel == 32'h0000_0028 |=>
		mem_rdata == {16'h0000, ring_table_entry_count[15:0]}) else $error("size read");
	a_size_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!(mem_wr && in_rt && rt_rel == 32'h0000_0028) |=>
		$stable(ring_table_entry_count[15:0])) else $error("size changed");
	a_base_low_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_rd && in_rt && word_sel == 4'h4 |=> mem_rdata[3:0] == 4'h0)
		else $error("base low bits set");
	a_base_hi_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_rt && rt_rel == 32'h0000_0034 |=>
		ring_table_base_field[63:32] == $past(mem_wdata)) else $error("base high lost");
	a_base_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!(mem_wr && in_rt && (rt_rel == 32'h0000_0030 || rt_rel == 32'h0000_0034)) |=>
		$stable(ring_table_base_field[63:0])) else $error("base changed");
	a_ptr_addr_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_rt && rt_rel == 32'h0000_0038 |=>
		ring_read_pointer_field[31:4] == $past(mem_wdata[31:4])) else $error("pointer lost");
	a_ptr_hi_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_rt && rt_rel == 32'h0000_003c |=>
		ring_read_pointer_field[63:32] == $past(mem_wdata)) else $error("pointer high lost");
	a_busy_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!handler_busy_set[0] && !(mem_rd && in_rt && rt_rel == 32'h0000_0038) |=>
		$stable(ring_read_pointer_field[3])) else $error("busy changed");
	a_db_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_db && !in_rt |=> db_index_ff == $past(db_rel[8:2]))
		else $error("doorbell index");
	a_db_stream: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mem_wr && in_db && !in_rt |=> ring_stream_id == $past(mem_wdata[31:16]))
		else $error("doorbell stream");
	a_db_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!(mem_wr && in_db && !in_rt) |=> !db_ring_ff) else $error("doorbell stray");
	// Set and read clear in one cycle: the set must win
	c_busy_race: cover property (@(posedge ref_clk)
		handler_busy_set[0] && mem_rd && in_rt && rt_rel == 32'h0000_0038);
endmodule

// file: core/erd_pkg.sv
// What this block does
// - Eight table size registers exist, one per interrupter, at runtime offset 28h plus 20h times n.
// - The table size register keeps a writable count in bits 15:0 and reads zero above.
// - Each interrupter has a 64-bit table base at 30h plus 20h times n with bits 3:0 read as zero.
// - Each interrupter has a 64-bit read pointer register at 38h plus 20h times n.
// - The read pointer address field from bit 4 upward is readable and writable.
// - Bits 2:0 of the read pointer are a writable segment index.
// - There are 65 doorbells of 32 bits, entry 0 for the controller, each at 04h times its index.
// - The first doorbell sits at the base address plus the programmed doorbell offset.
// - All these registers reset to zero.
// - The runtime base is the base address plus the programmed runtime offset.
// - A doorbell takes a target code in bits 7:0 and a stream id in 31:16 and reads zero.
package erd_pkg;
	localparam int NUM_INTR = 8;
	localparam int NUM_DOORBELL = 65;
	localparam logic [15:0] SET_STRIDE = 16'h0020;
	localparam logic [15:0] TBL_SIZE_OFF = 16'h0028;
	localparam logic [15:0] TBL_BASE_OFF = 16'h0030;
	localparam logic [15:0] RD_PTR_OFF = 16'h0038;
	localparam logic [15:0] DB_STRIDE = 16'h0004;
	localparam int BUSY_BIT = 3;
	localparam int TGT_LSB = 0;
	localparam int STREAM_LSB = 16;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;
	localparam logic [31:0] BASE_MASK_LO = 32'hffff_fff0;
	localparam logic [31:0] SIZE_MASK = 32'h0000_ffff;
endpackage

// file: core/erd_intr_set.sv
`timescale 1ns/1ps
module erd_intr_set (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Access
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] sel,
	input wire logic [31:0] wdata,
	input wire logic busy_set,
	// State
	output logic [31:0] rdata,
	output logic [15:0] ring_table_entry_count,
	output logic [63:0] ring_table_base_field,
	output logic [63:0] ring_read_pointer_field
);
	logic [15:0] size_ff;
	logic [59:0] base_ff;
	logic [59:0] ptr_ff;
	logic busy_ff;
	logic [2:0] idx_ff;

	// sel: 2 size, 4/5 base lo/hi, 6/7 pointer lo/hi
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			size_ff <= 16'h0000;
			base_ff <= 60'h0;
			ptr_ff <= 60'h0;
			idx_ff <= 3'h0;
		end else if (wr_en) begin
			case (sel)
				4'h2: size_ff <= wdata[15:0];
				4'h4: base_ff[27:0] <= wdata[31:4];
				4'h5: base_ff[59:28] <= wdata;
				4'h6: begin
					ptr_ff[27:0] <= wdata[31:4];
					idx_ff <= wdata[2:0];
				end
				4'h7: ptr_ff[59:28] <= wdata;
				default: begin
				end
			endcase
		end
	end

	// Set beats the read clear so no event is lost
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_ff <= 1'b0;
		end else if (busy_set) begin
			busy_ff <= 1'b1;
		end else if (rd_en && sel == 4'h6) begin
			busy_ff <= 1'b0;
		end
	end

	assign ring_table_entry_count = size_ff;
	assign ring_table_base_field = {base_ff, 4'h0};
	assign ring_read_pointer_field = {ptr_ff, busy_ff, idx_ff};

	always_comb begin
		case (sel)
			4'h2: rdata = {16'h0000, size_ff};
			4'h4: rdata = {base_ff[27:0], 4'h0};
			4'h5: rdata = base_ff[59:28];
			4'h6: rdata = {ptr_ff[27:0], busy_ff, idx_ff};
			4'h7: rdata = ptr_ff[59:28];
			default: rdata = 32'h0000_0000;
		endcase
	end
endmodule

// file: testbench/erd_regs_tb.sv
`timescale 1ns/1ps
module erd_regs_tb;
	// ****************
	// Bench state
	// ****************
	localparam logic [31:0] RT = 32'h1000_2000;
	localparam logic [31:0] DB = 32'h1000_3000;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] mem_addr = 32'h0;
	logic mem_wr = 1'b0;
	logic mem_rd = 1'b0;
	logic [31:0] mem_wdata = 32'h0;
	logic [7:0] busy_set = 8'h00;
	logic [31:0] mem_rdata;
	logic mem_rvalid;
	logic [127:0] cnt_o;
	logic [511:0] base_o;
	logic [511:0] ptr_o;
	logic db_ring_ff;
	logic [6:0] db_index_ff;
	logic [7:0] tgt;
	logic [15:0] sid;
	int n_errors = 0;
	int check_count = 0;
	erd_regs uut (.ref_clk(ref_clk), .reset_n(reset_n), .bar0_base(32'h1000_0000),
		.runtime_offset(32'h0000_2000), .doorbell_offset(32'h0000_3000),
		.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .handler_busy_set(busy_set),
		.ring_table_entry_count(cnt_o), .ring_table_base_field(base_o),
		.ring_read_pointer_field(ptr_o), .db_ring_ff(db_ring_ff), .db_index_ff(db_index_ff),
		.ring_target_code(tgt), .ring_stream_id(sid));
	always #50 ref_clk = ~ref_clk;
	// ****************
	// Access tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		mem_addr <= a;
		mem_wdata <= d;
		mem_wr <= 1'b1;
		@(posedge ref_clk);
		mem_wr <= 1'b0;
		#1;
	endtask
	// Read data is only looked at in its single valid cycle
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		mem_addr <= a;
		mem_rd <= 1'b1;
		@(posedge ref_clk);
		mem_rd <= 1'b0;
		#1;
		chk({31'h0, mem_rvalid}, 32'h1);
		chk(mem_rdata, exp);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_size;
		for (int n = 0; n < 8; n++) begin
			rd(RT + 32'h28 + 32'(n) * 32'h20, 32'h0);
			rd(RT + 32'h38 + 32'(n) * 32'h20, 32'h0);
			wr(RT + 32'h28 + 32'(n) * 32'h20, 32'hbeef_1230 + 32'(n));
			rd(RT + 32'h28 + 32'(n) * 32'h20, 32'h0000_1230 + 32'(n));
			chk({16'h0, cnt_o[n*16+:16]}, 32'h0000_1230 + 32'(n));
		end
		rd(RT + 32'h20, 32'h0);
		rd(RT + 32'h128, 32'h0);
		$display("size test done");
	endtask
	task automatic t_base;
		rd(RT + 32'h94, 32'h0);
		wr(RT + 32'h90, 32'hffff_ffff);
		wr(RT + 32'h94, 32'h1234_5678);
		rd(RT + 32'h90, 32'hffff_fff0);
		rd(RT + 32'h94, 32'h1234_5678);
		chk(base_o[3*64+:32], 32'hffff_fff0);
		$display("base test done");
	endtask
	// Busy bit is device set only, so a write of all ones leaves it low
	task automatic t_ptr;
		wr(RT + 32'hd8, 32'hffff_ffff);
		wr(RT + 32'hdc, 32'h0000_00a5);
		rd(RT + 32'hd8, 32'hffff_fff7);
		rd(RT + 32'hdc, 32'h0000_00a5);
		chk(ptr_o[5*64+:32], 32'hffff_fff7);
		@(posedge ref_clk);
		busy_set <= 8'h20;
		@(posedge ref_clk);
		busy_set <= 8'h00;
		rd(RT + 32'hd8, 32'hffff_ffff);
		rd(RT + 32'hd8, 32'hffff_fff7);
		$display("pointer test done");
	endtask
	task automatic t_db;
		for (int k = 0; k < 65; k += 32) begin
			wr(DB + 32'(k) * 32'h4, {16'hc000 + 16'(k), 8'h77, 8'h30 + 8'(k)});
			chk({31'h0, db_ring_ff}, 32'h1);
			chk({25'h0, db_index_ff}, 32'(k));
			chk({sid, tgt, 8'h0}, {16'hc000 + 16'(k), 8'h30 + 8'(k), 8'h0});
			rd(DB + 32'(k) * 32'h4, 32'h0);
			chk({31'h0, db_ring_ff}, 32'h0);
		end
		$display("doorbell test done");
	endtask
	// Set wins over the read clear in the same cycle
	task automatic t_race;
		@(posedge ref_clk);
		mem_addr <= RT + 32'h38;
		mem_rd <= 1'b1;
		busy_set <= 8'h01;
		@(posedge ref_clk);
		mem_rd <= 1'b0;
		busy_set <= 8'h00;
		#1;
		chk(mem_rdata, 32'h0);
		chk({31'h0, ptr_o[3]}, 32'h1);
		rd(RT + 32'h38, 32'h8);
		rd(RT + 32'h38, 32'h0);
		$display("busy race test done");
	endtask
	task automatic t_reset;
		wr(RT + 32'h28, 32'h0000_5555);
		wr(DB + 32'h8, 32'hc0de_0011);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		chk({16'h0, cnt_o[15:0]}, 32'h0);
		chk(base_o[3*64+32+:32], 32'h0);
		chk(ptr_o[5*64+:32], 32'h0);
		chk({sid, 8'h0, tgt}, 32'h0);
		chk({25'h0, db_index_ff}, 32'h0);
		rd(RT + 32'h28, 32'h0);
		rd(RT + 32'hdc, 32'h0);
		$display("reset test done");
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_size();
		t_base();
		t_ptr();
		t_db();
		t_race();
		t_reset();
		conclude();
	end
	initial begin
		#400000;
		n_errors++;
		conclude();
	end
endmodule
